// [hdl/uicf_pkg.sv]
// Constants shared by the interrupt identification and FIFO control block.
package uicf_pkg;

	// Register offsets on the internal register port.
	localparam int          ADDR_W        = 3;
	localparam logic [2:0]  OFS_DATA      = 3'h0;
	localparam logic [2:0]  OFS_DIV_HIGH  = 3'h1;
	localparam logic [2:0]  OFS_INT_ID    = 3'h2;

	// Field positions inside the FIFO control byte.
	localparam int          FC_FIFO_EN    = 0;
	localparam int          FC_RX_RST     = 1;
	localparam int          FC_TX_RST     = 2;
	localparam int          FC_TX_TRIG_LO = 4;
	localparam int          FC_RX_TRIG_LO = 6;

	// Reset values.
	localparam logic [7:0]  INT_ID_RESET  = 8'h01;
	localparam logic [7:0]  FC_RESET      = 8'h00;
	localparam logic [7:0]  DIV_HI_RESET  = 8'h00;
	localparam logic [1:0]  TRIG_RESET    = 2'h0;

	// FIFO occupancy counts, wide enough to hold a full FIFO.
	localparam int          CNT_W         = 7;
	localparam logic [6:0]  DEPTH_ON      = 7'h40;
	localparam logic [6:0]  DEPTH_OFF     = 7'h01;
	localparam logic [6:0]  RX_TRIG_0     = 7'h08;
	localparam logic [6:0]  RX_TRIG_1     = 7'h10;
	localparam logic [6:0]  RX_TRIG_2     = 7'h38;
	localparam logic [6:0]  RX_TRIG_3     = 7'h3C;
	localparam logic [6:0]  TX_TRIG_0     = 7'h08;
	localparam logic [6:0]  TX_TRIG_1     = 7'h10;
	localparam logic [6:0]  TX_TRIG_2     = 7'h20;
	localparam logic [6:0]  TX_TRIG_3     = 7'h38;

	// Identification codes for bits 5 to 0, in priority order.
	localparam logic [5:0]  IID_LINE_ERR  = 6'h06;
	localparam logic [5:0]  IID_RX_TMO    = 6'h0C;
	localparam logic [5:0]  IID_RX_DATA   = 6'h04;
	localparam logic [5:0]  IID_TX_HOLD   = 6'h02;
	localparam logic [5:0]  IID_MODEM     = 6'h00;
	localparam logic [5:0]  IID_GPIO      = 6'h30;
	localparam logic [5:0]  IID_XOFF      = 6'h10;
	localparam logic [5:0]  IID_CTS_RTS   = 6'h20;
	localparam logic [5:0]  IID_NONE      = 6'h01;

endpackage : uicf_pkg

// [hdl/uicf_fifo.sv]
// Character FIFO with a run-time capacity limit and a flush input.
`timescale 1ns/1ps
module uicf_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 64,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          mclk,
	input  wire logic          reset_n,
	input  wire logic          flush,
	input  wire logic [CW-1:0] cap,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [W-1:0]  in_data,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [W-1:0]       out_data,
	output logic [CW-1:0]      level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [W-1:0]  mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;
	logic          push;
	logic          pop;

	// Handshakes stall while a flush is in progress.
	assign in_ready  = (count_ff < cap) && !flush;
	assign out_valid = (count_ff != '0) && !flush;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rd_ptr_ff];
	assign level     = count_ff;

	// Storage array; data needs no reset.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// Pointers and occupancy; a flush empties the FIFO in one edge.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else if (flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

endmodule : uicf_fifo

// [hdl/uicf_int_encoder.sv]
// Priority encoder that builds the interrupt identification byte.
`timescale 1ns/1ps
module uicf_int_encoder (
	input  wire logic       fifo_en,
	input  wire logic       line_err,
	input  wire logic       rx_timeout,
	input  wire logic       rx_data,
	input  wire logic       tx_hold,
	input  wire logic       modem,
	input  wire logic       gpio_change,
	input  wire logic       xoff_special,
	input  wire logic       cts_rts_off,
	output logic [7:0]      int_id
);
	import uicf_pkg::*;

	// Picks the code of the most urgent pending source.
	function automatic logic [5:0] encode(input logic [7:0] src);
		logic [5:0] code;
		code = IID_NONE;
		if (src[0]) begin
			code = IID_LINE_ERR;
		end else if (src[1]) begin
			code = IID_RX_TMO;
		end else if (src[2]) begin
			code = IID_RX_DATA;
		end else if (src[3]) begin
			code = IID_TX_HOLD;
		end else if (src[4]) begin
			code = IID_MODEM;
		end else if (src[5]) begin
			code = IID_GPIO;
		end else if (src[6]) begin
			code = IID_XOFF;
		end else if (src[7]) begin
			code = IID_CTS_RTS;
		end
		return code;
	endfunction : encode

	// Top two bits mirror the FIFO enable; low six bits hold the code.
	assign int_id = {fifo_en, fifo_en,
		encode({cts_rts_off, xoff_special, gpio_change, modem,
			tx_hold, rx_data, rx_timeout, line_err})};

endmodule : uicf_int_encoder

// [hdl/uicf_ctrl.sv]
// Interrupt identification, FIFO control and divisor high byte of a channel.
//
// Behaviour
// - Identification bit 0 high means nothing pending.
// - Only the highest priority source is reported.
// - Line status error, priority 1, code 000110.
// - Timeout 001100, receive data 000100, priority 2.
// - Transmit holding, priority 3, code 000010.
// - Modem status, priority 4, code 000000.
// - Input pin change, priority 5, code 110000.
// - Flow-stop or special character, priority 6, 010000.
// - Handshake line going inactive, priority 7, 100000.
// - Bits 7:6 pick receive trigger 8/16/56/60.
// - Bits 5:4 pick transmit trigger 8/16/32/56.
// - Bit 2 flushes transmit FIFO, self-clears.
// - Bit 1 flushes receive FIFO, self-clears.
// - FIFO off: depth one, others unprogrammable.
// - Transmit trigger writable only with enhanced enable.
`timescale 1ns/1ps
module uicf_ctrl #(
	parameter int DATA_W = 8,
	parameter int DEPTH  = 64
) (
	input  wire logic                       mclk,
	input  wire logic                       reset_n,
	input  wire logic                       soft_reset,
	input  wire logic [uicf_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic [7:0]                 reg_wdata,
	output logic [7:0]                      reg_rdata,
	input  wire logic                       line_control_dlab,
	input  wire logic                       alt_bank_sel,
	input  wire logic                       enhanced_feature_en,
	input  wire logic                       rx_data_int_en,
	input  wire logic                       tx_hold_int_en,
	input  wire logic                       line_err_pend,
	input  wire logic                       rx_timeout_pend,
	input  wire logic                       modem_pend,
	input  wire logic                       gpio_change_pend,
	input  wire logic                       xoff_special_pend,
	input  wire logic                       cts_rts_off_pend,
	output logic                            tx_out_valid,
	input  wire logic                       tx_out_ready,
	output logic [DATA_W-1:0]               tx_out_data,
	input  wire logic                       rx_in_valid,
	output logic                            rx_in_ready,
	input  wire logic [DATA_W-1:0]          rx_in_data,
	output logic                            int_pending,
	output logic                            fifo_enabled,
	output logic [7:0]                      divisor_high,
	output logic [uicf_pkg::CNT_W-1:0]      rx_level,
	output logic [uicf_pkg::CNT_W-1:0]      tx_level,
	output logic                            tx_write_dropped
);
	import uicf_pkg::*;

	logic               fifo_en_ff;
	logic [1:0]         rx_trig_ff;
	logic [1:0]         tx_trig_ff;
	logic               tx_flush_ff;
	logic               rx_flush_ff;
	logic [7:0]         div_high_ff;
	logic [7:0]         rdata_ff;
	logic               int_pending_ff;
	logic               tx_drop_ff;
	logic               hit_data;
	logic               hit_div;
	logic               hit_int_id;
	logic               fc_wr;
	logic               fc_en_new;
	logic               nxt_tx_flush;
	logic               nxt_rx_flush;
	logic [CNT_W-1:0]   cap;
	logic [CNT_W-1:0]   rx_thresh;
	logic [CNT_W-1:0]   tx_thresh;
	logic [CNT_W-1:0]   tx_free;
	logic               rx_data_int;
	logic               tx_hold_int;
	logic [7:0]         int_id;
	logic               tx_in_ready;
	logic               rx_out_valid;
	logic [DATA_W-1:0]  rx_out_data;
	logic               tx_push_req;
	logic               rx_pop;

	// Address decode, shared by the read and write paths.
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs, input logic dlab_need,
		input logic dlab, input logic alt);
		return (addr == ofs) && (dlab == dlab_need) && !alt;
	endfunction : reg_hit

	// Trigger level from a two-bit select, for either direction.
	function automatic logic [CNT_W-1:0] trig_count(input logic [1:0] sel,
		input logic is_rx);
		logic [CNT_W-1:0] cnt;
		cnt = DEPTH_OFF;
		case (sel)
			2'h0: cnt = is_rx ? RX_TRIG_0 : TX_TRIG_0;
			2'h1: cnt = is_rx ? RX_TRIG_1 : TX_TRIG_1;
			2'h2: cnt = is_rx ? RX_TRIG_2 : TX_TRIG_2;
			2'h3: cnt = is_rx ? RX_TRIG_3 : TX_TRIG_3;
			default: cnt = DEPTH_OFF;
		endcase
		return cnt;
	endfunction : trig_count

	// Register selection on the internal register port.
	assign hit_data   = reg_hit(reg_addr, OFS_DATA, 1'b0,
		line_control_dlab, alt_bank_sel);
	assign hit_div    = reg_hit(reg_addr, OFS_DIV_HIGH, 1'b1,
		line_control_dlab, alt_bank_sel);
	assign hit_int_id = reg_hit(reg_addr, OFS_INT_ID, 1'b0,
		line_control_dlab, alt_bank_sel);

	// A write to the shared offset lands in FIFO control only.
	assign fc_wr     = reg_wr && hit_int_id;
	assign fc_en_new = reg_wdata[FC_FIFO_EN];

	// FIFO enable bit; soft reset returns it to off.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fifo_en_ff <= FC_RESET[FC_FIFO_EN];
		end else if (soft_reset) begin
			fifo_en_ff <= FC_RESET[FC_FIFO_EN];
		end else if (fc_wr) begin
			fifo_en_ff <= fc_en_new;
		end
	end

	// Receive trigger select, only taken while the write enables FIFOs.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_trig_ff <= TRIG_RESET;
		end else if (soft_reset) begin
			rx_trig_ff <= TRIG_RESET;
		end else if (fc_wr && fc_en_new) begin
			rx_trig_ff <= reg_wdata[FC_RX_TRIG_LO +: 2];
		end
	end

	// Transmit trigger select, further gated by the enhanced enable.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_trig_ff <= TRIG_RESET;
		end else if (soft_reset) begin
			tx_trig_ff <= TRIG_RESET;
		end else if (fc_wr && fc_en_new && enhanced_feature_en) begin
			tx_trig_ff <= reg_wdata[FC_TX_TRIG_LO +: 2];
		end
	end

	// Flush requests: soft reset, explicit reset bits, or a change of FIFO mode.
	// Bit 3 is never looked at, so writing it has no effect.
	always_comb begin
		nxt_tx_flush = soft_reset;
		nxt_rx_flush = soft_reset;
		if (fc_wr && (fc_en_new != fifo_en_ff)) begin
			nxt_tx_flush = 1'b1;
			nxt_rx_flush = 1'b1;
		end
		if (fc_wr && fc_en_new) begin
			if (reg_wdata[FC_TX_RST]) begin
				nxt_tx_flush = 1'b1;
			end
			if (reg_wdata[FC_RX_RST]) begin
				nxt_rx_flush = 1'b1;
			end
		end
	end

	// Self-clearing reset bits: high for the one edge the flush takes.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_flush_ff <= 1'b0;
			rx_flush_ff <= 1'b0;
		end else begin
			tx_flush_ff <= nxt_tx_flush;
			rx_flush_ff <= nxt_rx_flush;
		end
	end

	// Divisor high byte; only power-on reset clears it.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_high_ff <= DIV_HI_RESET;
		end else if (reg_wr && hit_div) begin
			div_high_ff <= reg_wdata;
		end
	end

	// Capacity and trigger thresholds follow the FIFO mode.
	assign cap       = fifo_en_ff ? DEPTH_ON : DEPTH_OFF;
	assign rx_thresh = fifo_en_ff ? trig_count(rx_trig_ff, 1'b1)
		: DEPTH_OFF;
	assign tx_thresh = fifo_en_ff ? trig_count(tx_trig_ff, 1'b0)
		: DEPTH_OFF;
	// Clamped, so a level left over from a mode change cannot wrap around.
	assign tx_free   = (tx_level >= cap) ? '0 : cap - tx_level;

	// Level-based data interrupts derived from the FIFO occupancy.
	assign rx_data_int = rx_data_int_en && (rx_level >= rx_thresh);
	assign tx_hold_int = tx_hold_int_en && (tx_free >= tx_thresh);

	// Host writes to the data offset go to the transmit FIFO.
	assign tx_push_req = reg_wr && hit_data;
	assign rx_pop      = reg_rd && hit_data && rx_out_valid;

	// Transmit FIFO; the serializer drains it and may stall.
	uicf_fifo #(
		.W     (DATA_W),
		.DEPTH (DEPTH),
		.CW    (CNT_W)
	) u_tx_fifo (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.flush     (tx_flush_ff),
		.cap       (cap),
		.in_valid  (tx_push_req),
		.in_ready  (tx_in_ready),
		.in_data   (reg_wdata[DATA_W-1:0]),
		.out_valid (tx_out_valid),
		.out_ready (tx_out_ready),
		.out_data  (tx_out_data),
		.level     (tx_level)
	);

	// Receive FIFO; the deserializer fills it, host reads drain it.
	uicf_fifo #(
		.W     (DATA_W),
		.DEPTH (DEPTH),
		.CW    (CNT_W)
	) u_rx_fifo (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.flush     (rx_flush_ff),
		.cap       (cap),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_in_data),
		.out_valid (rx_out_valid),
		.out_ready (rx_pop),
		.out_data  (rx_out_data),
		.level     (rx_level)
	);

	// Priority encoding of all pending sources.
	uicf_int_encoder u_int_enc (
		.fifo_en      (fifo_en_ff),
		.line_err     (line_err_pend),
		.rx_timeout   (rx_timeout_pend),
		.rx_data      (rx_data_int),
		.tx_hold      (tx_hold_int),
		.modem        (modem_pend),
		.gpio_change  (gpio_change_pend),
		.xoff_special (xoff_special_pend),
		.cts_rts_off  (cts_rts_off_pend),
		.int_id       (int_id)
	);

	// Read data, registered one edge after the read strobe.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			if (hit_int_id) begin
				rdata_ff <= int_id;
			end else if (hit_div) begin
				rdata_ff <= div_high_ff;
			end else if (hit_data && rx_out_valid) begin
				rdata_ff <= 8'(rx_out_data);
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	// Pending flag, active when the identification bit 0 is low.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			int_pending_ff <= ~INT_ID_RESET[0];
		end else begin
			int_pending_ff <= ~int_id[0];
		end
	end

	// Sticky note of a host write lost to a full or flushing transmit FIFO.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_drop_ff <= 1'b0;
		end else if (tx_push_req && !tx_in_ready) begin
			tx_drop_ff <= 1'b1;
		end else if (soft_reset) begin
			tx_drop_ff <= 1'b0;
		end
	end

	// Outputs.
	assign reg_rdata        = rdata_ff;
	assign int_pending      = int_pending_ff;
	assign fifo_enabled     = fifo_en_ff;
	assign divisor_high     = div_high_ff;
	assign tx_write_dropped = tx_drop_ff;

endmodule : uicf_ctrl

// [dv/uicf_ctrl_checker.sv]
// Concurrent checks on the ports of the identification and FIFO control block.
`timescale 1ns/1ps
module uicf_ctrl_checker #(
	parameter int DATA_W = 8,
	parameter int DEPTH  = 64
) (
	input wire logic                        mclk,
	input wire logic                        reset_n,
	input wire logic                        soft_reset,
	input wire logic [uicf_pkg::ADDR_W-1:0] reg_addr,
	input wire logic                        reg_wr,
	input wire logic                        reg_rd,
	input wire logic [7:0]                  reg_wdata,
	input wire logic [7:0]                  reg_rdata,
	input wire logic                        line_control_dlab,
	input wire logic                        alt_bank_sel,
	input wire logic                        line_err_pend,
	input wire logic                        rx_timeout_pend,
	input wire logic                        modem_pend,
	input wire logic                        gpio_change_pend,
	input wire logic                        xoff_special_pend,
	input wire logic                        cts_rts_off_pend,
	input wire logic                        int_pending,
	input wire logic                        fifo_enabled,
	input wire logic [7:0]                  divisor_high,
	input wire logic [uicf_pkg::CNT_W-1:0]  rx_level,
	input wire logic [uicf_pkg::CNT_W-1:0]  tx_level
);
	import uicf_pkg::*;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// Decoded writes to the shared control offset and the divisor byte, reads of the identification byte, and any of the six pending source inputs.
	wire fc_wr = reg_wr && reg_addr == OFS_INT_ID && !line_control_dlab
		&& !alt_bank_sel;
	wire dv_wr = reg_wr && reg_addr == OFS_DIV_HIGH && line_control_dlab
		&& !alt_bank_sel;
	wire id_rd = reg_rd && reg_addr == OFS_INT_ID && !line_control_dlab
		&& !alt_bank_sel;
	wire any_src = line_err_pend || rx_timeout_pend || modem_pend
		|| gpio_change_pend || xoff_special_pend || cts_rts_off_pend;

	// Soft reset drops the enable at once, then both FIFOs read empty.
	sequence s_soft_clear;
		(!fifo_enabled && divisor_high == $past(divisor_high))
		##1 (rx_level == 0 && tx_level == 0);
	endsequence

	property p_rdata_hold;
		$changed(reg_rdata) |-> $past(reg_rd) || $past(reg_rd, 2);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without a read");
	property p_fe_write;
		fc_wr && !soft_reset |=> fifo_enabled == $past(reg_wdata[0]);
	endproperty
	a_fe_write: assert property (p_fe_write)
		else $error("FIFO enable not taken from the write");
	property p_fe_cause;
		$changed(fifo_enabled) |-> $past(fc_wr) || $past(soft_reset);
	endproperty
	a_fe_cause: assert property (p_fe_cause)
		else $error("FIFO enable changed without a control write");
	property p_div_write;
		dv_wr |=> divisor_high == $past(reg_wdata);
	endproperty
	a_div_write: assert property (p_div_write)
		else $error("divisor high byte not written");
	property p_div_cause;
		$changed(divisor_high) |-> $past(dv_wr);
	endproperty
	a_div_cause: assert property (p_div_cause)
		else $error("divisor high byte changed without a write");
	property p_int_any;
		any_src |=> int_pending;
	endproperty
	a_int_any: assert property (p_int_any)
		else $error("pending source not flagged");
	property p_soft_clear;
		soft_reset |=> s_soft_clear;
	endproperty
	a_soft_clear: assert property (p_soft_clear)
		else $error("soft reset result wrong");
	property p_tx_flush;
		fc_wr && reg_wdata[0] && reg_wdata[2] |-> ##2 tx_level == 0;
	endproperty
	a_tx_flush: assert property (p_tx_flush)
		else $error("transmit FIFO not flushed");
	property p_rx_flush;
		fc_wr && reg_wdata[0] && reg_wdata[1] |-> ##2 rx_level == 0;
	endproperty
	a_rx_flush: assert property (p_rx_flush)
		else $error("receive FIFO not flushed");
	property p_id_mirror;
		id_rd |=> reg_rdata[7:6] == {2{$past(fifo_enabled)}};
	endproperty
	a_id_mirror: assert property (p_id_mirror)
		else $error("identification top bits do not mirror FIFO enable");
	property p_id_pend;
		id_rd && any_src |=> !reg_rdata[0];
	endproperty
	a_id_pend: assert property (p_id_pend)
		else $error("identification bit 0 high with a source pending");
endmodule : uicf_ctrl_checker

// [dv/testbench.sv]
// Self-checking bench for the identification and FIFO control block.
`timescale 1ns/1ps
module testbench;
	import uicf_pkg::*;
	logic       mclk, reset_n, soft_reset, reg_wr, reg_rd;
	logic       dlab, alt, enh, tx_out_ready, rx_in_valid;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, rx_in_data, src, reg_rdata, tx_out_data;
	logic [7:0] divisor_high;
	logic [6:0] rx_level, tx_level;
	logic       tx_out_valid, rx_in_ready, int_pending, fifo_enabled;
	logic       tx_write_dropped;
	int         error_cnt, checked, cyc;
	logic [5:0] code [8] = '{IID_LINE_ERR, IID_RX_TMO,
		IID_RX_DATA, IID_TX_HOLD, IID_MODEM,
		IID_GPIO, IID_XOFF, IID_CTS_RTS};

	uicf_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .soft_reset(soft_reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.line_control_dlab(dlab), .alt_bank_sel(alt),
		.enhanced_feature_en(enh), .rx_data_int_en(src[2]),
		.tx_hold_int_en(src[3]), .line_err_pend(src[0]),
		.rx_timeout_pend(src[1]), .modem_pend(src[4]),
		.gpio_change_pend(src[5]), .xoff_special_pend(src[6]),
		.cts_rts_off_pend(src[7]), .tx_out_valid(tx_out_valid),
		.tx_out_ready(tx_out_ready), .tx_out_data(tx_out_data),
		.rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
		.rx_in_data(rx_in_data), .int_pending(int_pending),
		.fifo_enabled(fifo_enabled), .divisor_high(divisor_high),
		.rx_level(rx_level), .tx_level(tx_level),
		.tx_write_dropped(tx_write_dropped));

	// Free-running 40 MHz clock.
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// Compares one byte-wide result and counts it.
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
			error_cnt++;
		if (g !== e)
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
	endtask : chk

	// One register write, strobe high for a single edge.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr

	// One register read; the data stands from the edge after the read.
	task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(posedge mclk);
		#1 chk(n, e, reg_rdata);
	endtask : rdc

	// Pushes one received character for a single edge.
	task automatic rxp(input logic [7:0] d);
		@(posedge mclk);
		rx_in_valid <= 1'h1;
		rx_in_data  <= d;
		@(posedge mclk);
		rx_in_valid <= 1'h0;
	endtask : rxp

	// Lets a number of edges pass, then settles.
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : idle

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// Cuts a hang short well past the expected run length.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	// Main sequence of register accesses and expected results.
	initial begin
		{soft_reset, reg_wr, reg_rd, dlab, alt, enh} = 6'h00;
		{tx_out_ready, rx_in_valid, reg_addr} = 5'h00;
		{reg_wdata, rx_in_data, src} = 24'h000000;
		reset_n = 1'h0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'h1;
		rdc(OFS_INT_ID, INT_ID_RESET, "id reset");
		chk("div reset", DIV_HI_RESET, divisor_high);
		@(posedge mclk) dlab <= 1'h1;
		wr(OFS_DIV_HIGH, 8'hA5);
		rdc(OFS_DIV_HIGH, 8'hA5, "div rw");
		@(posedge mclk) dlab <= 1'h0;
		// FIFO on, eight characters received, then sources added by rank.
		wr(OFS_INT_ID, 8'h01);
		for (int k = 0; k < 8; k++)
			rxp(8'h10 + k[7:0]);
		for (int k = 7; k >= 0; k--) begin
			@(posedge mclk) src <= 8'(8'hFF << k);
			rdc(OFS_INT_ID, {2'h3, code[k]}, "id prio");
			chk("pending", 8'h01, {7'h00, int_pending});
		end
		// Receive trigger levels around eight and fifty-six characters.
		@(posedge mclk) src <= 8'h04;
		wr(OFS_INT_ID, 8'h41);
		rdc(OFS_INT_ID, 8'hC1, "rx trig 16");
		wr(OFS_INT_ID, 8'h01);
		rdc(OFS_INT_ID, 8'hC4, "rx trig 8");
		for (int k = 8; k < 56; k++)
			rxp(8'h10 + k[7:0]);
		wr(OFS_INT_ID, 8'h81);
		rdc(OFS_INT_ID, 8'hC4, "rx trig 56");
		wr(OFS_INT_ID, 8'hC1);
		rdc(OFS_INT_ID, 8'hC1, "rx trig 60");
		rdc(OFS_DATA, 8'h10, "rx head");
		wr(OFS_INT_ID, 8'h03);
		idle(2);
		chk("rx flush", 8'h00, {1'h0, rx_level});
		// Transmit trigger levels, gated by the enhanced enable.
		@(posedge mclk) src <= 8'h08;
		enh <= 1'h1;
		wr(OFS_INT_ID, 8'h31);
		for (int k = 0; k < 9; k++)
			wr(OFS_DATA, k[7:0]);
		rdc(OFS_INT_ID, 8'hC1, "tx trig 56");
		@(posedge mclk) enh <= 1'h0;
		wr(OFS_INT_ID, 8'h01);
		rdc(OFS_INT_ID, 8'hC1, "tx trig gated");
		@(posedge mclk) enh <= 1'h1;
		wr(OFS_INT_ID, 8'h21);
		rdc(OFS_INT_ID, 8'hC2, "tx trig 32");
		// Fill the transmit FIFO past full, then drain with stalls.
		for (int k = 9; k < 65; k++)
			wr(OFS_DATA, (k == 64) ? 8'hEE : k[7:0]);
		idle(1);
		chk("tx full", 8'h40, {1'h0, tx_level});
		chk("tx drop", 8'h01, {7'h00, tx_write_dropped});
		for (int k = 0; k < 64; k++) begin
			@(posedge mclk) tx_out_ready <= 1'h1;
			@(negedge mclk) chk("tx data", k[7:0], tx_out_data);
			chk("tx valid", 8'h01, {7'h00, tx_out_valid});
			@(posedge mclk) tx_out_ready <= 1'h0;
		end
		idle(1);
		chk("tx empty", 8'h00, {1'h0, tx_level});
		chk("tx idle", 8'h00, {7'h00, tx_out_valid});
		for (int k = 0; k < 3; k++)
			wr(OFS_DATA, k[7:0]);
		// Reserved bit 3 must not flush anything.
		wr(OFS_INT_ID, 8'h09);
		idle(1);
		chk("bit 3", 8'h03, {1'h0, tx_level});
		wr(OFS_INT_ID, 8'h05);
		idle(2);
		chk("tx flush", 8'h00, {1'h0, tx_level});
		// FIFO off: one character per direction.
		wr(OFS_INT_ID, 8'h00);
		rdc(OFS_INT_ID, 8'h02, "id fifo off");
		wr(OFS_DATA, 8'h01);
		wr(OFS_DATA, 8'h02);
		idle(1);
		chk("tx depth 1", 8'h01, {1'h0, tx_level});
		rxp(8'h33);
		rxp(8'h34);
		idle(1);
		chk("rx depth 1", 8'h01, {1'h0, rx_level});
		chk("rx ready", 8'h00, {7'h00, rx_in_ready});
		// Other bank and unmapped offsets read as zero.
		@(posedge mclk) alt <= 1'h1;
		rdc(OFS_INT_ID, 8'h00, "alt bank");
		@(posedge mclk) alt <= 1'h0;
		rdc(3'h7, 8'h00, "unmapped");
		// Soft reset keeps the divisor byte.
		wr(OFS_INT_ID, 8'h01);
		@(posedge mclk) soft_reset <= 1'h1;
		@(posedge mclk) soft_reset <= 1'h0;
		idle(1);
		chk("soft fe", 8'h00, {7'h00, fifo_enabled});
		chk("soft drop", 8'h00, {7'h00, tx_write_dropped});
		@(posedge mclk) dlab <= 1'h1;
		rdc(OFS_DIV_HIGH, 8'hA5, "div kept");
		summarize();
	end
endmodule : testbench

bind uicf_ctrl uicf_ctrl_checker #(.DATA_W(DATA_W), .DEPTH(DEPTH)) chk_u (
	.mclk(mclk), .reset_n(reset_n), .soft_reset(soft_reset),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.line_control_dlab(line_control_dlab), .alt_bank_sel(alt_bank_sel),
	.line_err_pend(line_err_pend), .rx_timeout_pend(rx_timeout_pend),
	.modem_pend(modem_pend), .gpio_change_pend(gpio_change_pend),
	.xoff_special_pend(xoff_special_pend),
	.cts_rts_off_pend(cts_rts_off_pend), .int_pending(int_pending),
	.fifo_enabled(fifo_enabled), .divisor_high(divisor_high),
	.rx_level(rx_level), .tx_level(tx_level));
